// ---- design/mic_cmd_ctrl.sv ----
// Command interpreter of the magnetometer: decodes I2C commands, runs measurements,
// frames reads, drives the threshold output.
// Assumes sensor samples from an outside converter and a user memory beside it.
`timescale 1ns/1ps
`default_nettype none
module mic_cmd_ctrl import mic_pkg::*; #(
    parameter int unsigned INTERVAL_CYC = BASE_INTERVAL_CYC,
    parameter int unsigned MEAS_CYC = MEAS_TIME_CYC
) (
    // System
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // I2C link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Sensor
    input wire logic [23:0] field_raw_in,
    input wire logic [23:0] temp_raw_in,
    input wire logic sat_in,
    input wire logic supply_ok_in,
    // Stored parameters
    input wire logic [6:0] stored_addr_in,
    input wire logic [2:0] cyclic_interval_code_in,
    input wire logic [1:0] threshold_mode_in,
    input wire logic [23:0] threshold_one_in,
    input wire logic [23:0] threshold_two_in,
    input wire logic [23:0] field_offset_in,
    input wire logic [23:0] temp_offset_in,
    input wire logic mem_error_in,
    // User memory port
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic [5:0] mem_addr_out,
    output logic [15:0] mem_wdata_out,
    input wire logic [15:0] mem_rdata_in,
    output logic checksum_out,
    // Threshold output and state
    output logic dout_out,
    output logic cyclic_out,
    output logic busy_out
);
    if (INTERVAL_CYC < 1 || MEAS_CYC < 1) begin : g_bad_timing
        $error("bad timing parameters");
    end
    // Address latched once after reset release
    logic [6:0] addr_q;
    logic addr_done_q;
    wire addr_ok = stored_addr_in >= ADDR_MIN;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            addr_q <= ADDR_DEFAULT;
            addr_done_q <= 1'b0;
        end else if (!addr_done_q) begin
            addr_q <= addr_ok ? stored_addr_in : ADDR_DEFAULT;
            addr_done_q <= 1'b1;
        end
    end
    // Link synchronisers and reset for the link domain
    logic lr1_q, lr2_q;
    always_ff @(posedge scl_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lr1_q <= 1'b0;
            lr2_q <= 1'b0;
        end else begin
            lr1_q <= 1'b1;
            lr2_q <= lr1_q;
        end
    end
    logic [7:0] rx_byte, tx_byte_q;
    logic rx_first, rx_tgl, end_tgl;
    logic [2:0] tx_idx;
    // Slave only, addressed by the external master
    mic_i2c_slave u_slave (
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe_out),
        .link_rst_n_in(lr2_q),
        .addr_in(addr_q),
        .rx_byte_out(rx_byte),
        .rx_first_out(rx_first),
        .rx_tgl_out(rx_tgl),
        .tx_idx_out(tx_idx),
        .tx_byte_in(tx_byte_q),
        .end_tgl_out(end_tgl)
    );
    logic [2:0] rt1_q, rt2_q, rt3_q;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rt1_q <= 3'h0;
            rt2_q <= 3'h0;
            rt3_q <= 3'h0;
        end else begin
            rt1_q <= {end_tgl, rx_tgl, rx_first};
            rt2_q <= rt1_q;
            rt3_q <= rt2_q;
        end
    end
    // Byte held stable long before its toggle is seen, so a plain capture is safe
    wire rx_ev = rt2_q[1] != rt3_q[1];
    wire rx_is_first = rt2_q[0];
    wire end_ev = rt2_q[2] != rt3_q[2];
    // Command state
    mic_state_e state_q, state_d;
    logic [7:0] cmd_q;
    logic [1:0] wcnt_q;
    logic [15:0] wdat_q;
    logic [4:0] nleft_q;
    logic [3:0] shift_q;
    logic [27:0] facc_q, tacc_q;
    logic [23:0] field_q, temp_q;
    logic [15:0] mdata_q;
    logic sat_q, mem_mode_q;
    logic [$clog2(MEAS_CYC+1)-1:0] mcnt_q;
    logic [31:0] icnt_q;
    logic cyc_q;
    wire is_rd = rx_byte >= CMD_RD_LO && rx_byte <= CMD_RD_HI;
    wire is_wr = rx_byte >= CMD_WR_LO && rx_byte <= CMD_WR_HI;
    wire is_ovs = rx_byte >= CMD_OVS2 && rx_byte <= CMD_OVS16;
    wire [1:0] ovs_sel = 2'(rx_byte - CMD_OVS2);
    wire busy = state_q != MIC_IDLE && state_q != MIC_DONE;
    wire cmd_ev = rx_ev && rx_is_first;
    wire take_cmd = cmd_ev && !busy;
    wire stop_cmd = cmd_ev && cyc_q && rx_byte == CMD_STOP;
    // Interval in cycles: base doubled per code step
    wire cyclic_interval_code_ok = cyclic_interval_code_in >= CYCLIC_INTERVAL_CODE_MIN && cyclic_interval_code_in <= CYCLIC_INTERVAL_CODE_MAX;
    wire [31:0] interval = 32'(INTERVAL_CYC) << (cyclic_interval_code_in - CYCLIC_INTERVAL_CODE_MIN);
    wire tick = cyc_q && cyclic_interval_code_ok && icnt_q >= interval - 32'h1;
    // Offsets applied in sign-magnitude form, clamped to code range
    function automatic logic [23:0] apply_field_offset(input logic [23:0] raw, input logic [23:0] field_offset);
        logic [24:0] mag;
        logic [24:0] sum;
        mag = {2'b00, field_offset[22:0]};
        sum = 25'h000_0000;
        if (field_offset[23]) begin
            sum = {1'b0, raw} - mag;
            apply_field_offset = sum[24] ? 24'h00_0000 : sum[23:0];
        end else begin
            sum = {1'b0, raw} + mag;
            apply_field_offset = sum[24] ? FULL_SCALE : sum[23:0];
        end
    endfunction
    wire [23:0] f_adj = sat_in ? FULL_SCALE : apply_field_offset(field_raw_in, field_offset_in);
    wire [23:0] t_adj = apply_field_offset(temp_raw_in, temp_offset_in);
    wire meas_end = state_q == MIC_MEAS && mcnt_q == MEAS_CYC[$bits(mcnt_q)-1:0];
    // Second-level state
    always_comb begin
        state_d = state_q;
        case (state_q)
            MIC_IDLE, MIC_DONE: begin
                if (take_cmd && (rx_byte == CMD_SINGLE || is_ovs)) state_d = MIC_MEAS;
                else if (take_cmd && rx_byte == CMD_CYCLIC) state_d = MIC_CYCLIC;
                else if (take_cmd) state_d = MIC_DONE;
            end
            MIC_MEAS: if (meas_end) state_d = MIC_ACC;
            MIC_ACC: state_d = nleft_q == 5'h1 ? MIC_DONE : MIC_MEAS;
            MIC_CYCLIC: if (stop_cmd) state_d = MIC_DONE;
            default: state_d = MIC_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) state_q <= MIC_IDLE;
        else state_q <= state_d;
    end
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cmd_q <= 8'h00;
            nleft_q <= 5'h0;
            shift_q <= 4'h0;
            mcnt_q <= '0;
            facc_q <= 28'h000_0000;
            tacc_q <= 28'h000_0000;
            mem_mode_q <= 1'b0;
        end else begin
            mcnt_q <= state_q == MIC_MEAS ? mcnt_q + 1'b1 : '0;
            if (take_cmd) begin
                cmd_q <= rx_byte;
                mem_mode_q <= is_rd || is_wr;
                nleft_q <= is_ovs ? 5'(5'h2 << ovs_sel) : 5'h1;
                shift_q <= is_ovs ? 4'(ovs_sel) + 4'h1 : 4'h0;
                facc_q <= 28'h000_0000;
                tacc_q <= 28'h000_0000;
            end else if (state_q == MIC_ACC) begin
                facc_q <= facc_q + {4'h0, f_adj};
                tacc_q <= tacc_q + {4'h0, t_adj};
                nleft_q <= nleft_q - 5'h1;
            end
        end
    end
    // Results: averaged into the read buffer; cyclic ticks and reads sample directly
    wire [27:0] f_sum = facc_q + {4'h0, f_adj};
    wire [27:0] t_sum = tacc_q + {4'h0, t_adj};
    wire meas_fin = state_q == MIC_ACC && nleft_q == 5'h1;
    wire rd_end_cyc = end_ev && cyc_q;
    wire refresh = tick || rd_end_cyc;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            field_q <= 24'h00_0000;
            temp_q <= 24'h00_0000;
            sat_q <= 1'b0;
        end else if (meas_fin) begin
            field_q <= 24'(f_sum >> shift_q);
            temp_q <= 24'(t_sum >> shift_q);
            sat_q <= sat_in;
        end else if (refresh) begin
            field_q <= f_adj;
            temp_q <= t_adj;
            sat_q <= sat_in;
        end
    end
    // Cyclic flag and interval timer
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cyc_q <= 1'b0;
            icnt_q <= 32'h0;
        end else begin
            cyc_q <= state_d == MIC_CYCLIC;
            icnt_q <= (!cyc_q || tick) ? 32'h0 : icnt_q + 32'h1;
        end
    end
    // Memory commands; parameter access blocked in cyclic mode
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wcnt_q <= 2'h0;
            wdat_q <= 16'h0000;
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            mem_addr_out <= 6'h00;
            mem_wdata_out <= 16'h0000;
            checksum_out <= 1'b0;
            mdata_q <= 16'h0000;
        end else begin
            mem_rd_out <= take_cmd && is_rd;
            mem_wr_out <= 1'b0;
            checksum_out <= take_cmd && rx_byte == CMD_CHECKSUM;
            if (take_cmd && (is_rd || is_wr)) begin
                mem_addr_out <= rx_byte[5:0];
                wcnt_q <= is_wr ? 2'h2 : 2'h0;
            end else if (rx_ev && !rx_is_first && wcnt_q != 2'h0 && !cyc_q) begin
                wdat_q <= {wdat_q[7:0], rx_byte};
                wcnt_q <= wcnt_q - 2'h1;
                if (wcnt_q == 2'h1) begin
                    mem_wr_out <= 1'b1;
                    mem_wdata_out <= {wdat_q[7:0], rx_byte};
                end
            end
            if (mem_rd_out) mdata_q <= mem_rdata_in;
            else if (mem_wr_out) mdata_q <= mem_wdata_out;
        end
    end
    // Status byte and read framing
    wire [7:0] status = (8'(supply_ok_in) << ST_VOK) | (8'(busy) << ST_BUSY)
        | (8'(mem_error_in) << ST_MEMERR) | (8'(sat_q) << ST_SAT);
    logic [7:0] tx_sel;
    always_comb begin
        tx_sel = 8'h00;
        case (tx_idx)
            3'h0: tx_sel = status;
            3'h1: tx_sel = mem_mode_q ? mdata_q[15:8] : field_q[23:16];
            3'h2: tx_sel = mem_mode_q ? mdata_q[7:0] : field_q[15:8];
            3'h3: tx_sel = field_q[7:0];
            3'h4: tx_sel = temp_q[23:16];
            3'h5: tx_sel = temp_q[15:8];
            3'h6: tx_sel = temp_q[7:0];
            default: tx_sel = 8'h00;
        endcase
    end
    // Data retained until the next command outside cyclic mode, so reads repeat
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) tx_byte_q <= 8'h00;
        else tx_byte_q <= tx_sel;
    end
    // Threshold comparator, refreshed with each new result
    logic dout_d;
    always_comb begin
        case (threshold_mode_in)
            TMODE_HIGH: dout_d = field_q > threshold_one_in;
            TMODE_INV: dout_d = field_q < threshold_one_in;
            TMODE_WIN: dout_d = threshold_one_in > threshold_two_in
                ? (field_q > threshold_one_in || field_q < threshold_two_in)
                : (field_q > threshold_one_in && field_q < threshold_two_in);
            default: dout_d = 1'b0;
        endcase
    end
    logic upd_q;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            upd_q <= 1'b0;
            dout_out <= 1'b0;
        end else begin
            upd_q <= meas_fin || refresh;
            if (upd_q) dout_out <= dout_d;
        end
    end
    assign cyclic_out = cyc_q;
    assign busy_out = busy;
    // Assertions
    property p_busy_ignore;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
            (busy && cmd_ev && !stop_cmd) |=> $stable(cmd_q);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");
    property p_cyc_busy;
        @(posedge clk_sys_in) disable iff (!reset_n_in) cyc_q |-> busy;
    endproperty
    a_cyc_busy: assert property (p_cyc_busy) else $error("cyclic but not busy");
    property p_start_cyc;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
            (take_cmd && rx_byte == CMD_CYCLIC) |=> ##1 cyc_q;
    endproperty
    a_start_cyc: assert property (p_start_cyc) else $error("cyclic not started");
    property p_stop_cyc;
        @(posedge clk_sys_in) disable iff (!reset_n_in) stop_cmd |=> ##1 !cyc_q;
    endproperty
    a_stop_cyc: assert property (p_stop_cyc) else $error("cyclic not stopped");
    property p_no_wr_cyc;
        @(posedge clk_sys_in) disable iff (!reset_n_in) $past(cyc_q) |-> !mem_wr_out && !mem_rd_out;
    endproperty
    a_no_wr_cyc: assert property (p_no_wr_cyc) else $error("parameter access in cyclic");
    property p_checksum;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
            (take_cmd && rx_byte == CMD_CHECKSUM) |=> checksum_out;
    endproperty
    a_checksum: assert property (p_checksum) else $error("checksum not requested");
    property p_single_done;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
            (take_cmd && rx_byte == CMD_SINGLE) |=> busy ##[1:40] !busy;
    endproperty
    a_single_done: assert property (p_single_done) else $error("single measurement stuck");
    property p_sat_field;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
            (refresh && sat_in) |=> field_q == FULL_SCALE && sat_q;
    endproperty
    a_sat_field: assert property (p_sat_field) else $error("saturation not flagged");
    property p_status_busy;
        @(posedge clk_sys_in) disable iff (!reset_n_in) status[ST_BUSY] == busy;
    endproperty
    a_status_busy: assert property (p_status_busy) else $error("status busy bit wrong");
    c_single: cover property (@(posedge clk_sys_in) take_cmd && rx_byte == CMD_SINGLE);
    c_ovs16: cover property (@(posedge clk_sys_in) take_cmd && rx_byte == CMD_OVS16);
    c_tick: cover property (@(posedge clk_sys_in) tick);
    c_memwr: cover property (@(posedge clk_sys_in) mem_wr_out);
endmodule : mic_cmd_ctrl
`default_nettype wire

// ---- design/mic_i2c_slave.sv ----
// I2C slave byte engine on the SCL domain, with open-drain SDA as three signals.
// Assumes SCL and SDA arrive from the bus; the SCL pin clocks this logic directly.
`timescale 1ns/1ps
`default_nettype none
module mic_i2c_slave import mic_pkg::*; (
    // Link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic link_rst_n_in,
    // Address
    input wire logic [6:0] addr_in,
    // Received bytes: toggle per byte, first flag set on first byte of a write
    output logic [7:0] rx_byte_out,
    output logic rx_first_out,
    output logic rx_tgl_out,
    // Read data: index of byte being sent, byte supplied by the core
    output logic [2:0] tx_idx_out,
    input wire logic [7:0] tx_byte_in,
    // Read end toggle, flipped by the master's not-acknowledge
    output logic end_tgl_out
);
    logic start_q, stop_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic adr_ph_q, sel_q, rd_q, ack_ph_q, first_q, nack_q;
    // Start and stop are detected on SDA edges while SCL is high
    always_ff @(negedge sda_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) start_q <= 1'b0;
        else start_q <= scl_in ? ~start_q : start_q;
    end
    always_ff @(posedge sda_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) stop_q <= 1'b0;
        else stop_q <= scl_in ? ~stop_q : stop_q;
    end
    logic start_seen_q, stop_seen_q;
    wire new_start = start_q != start_seen_q;
    always_ff @(posedge scl_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) begin
            start_seen_q <= 1'b0;
            stop_seen_q <= 1'b0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            adr_ph_q <= 1'b0;
            sel_q <= 1'b0;
            rd_q <= 1'b0;
            first_q <= 1'b0;
            rx_byte_out <= 8'h00;
            rx_first_out <= 1'b0;
            rx_tgl_out <= 1'b0;
            tx_idx_out <= 3'h0;
            nack_q <= 1'b0;
            end_tgl_out <= 1'b0;
        end else begin
            start_seen_q <= start_q;
            if (stop_q != stop_seen_q) begin
                stop_seen_q <= stop_q;
                sel_q <= 1'b0;
            end
            if (new_start) begin
                bit_q <= 4'h1;
                sh_q <= {7'h00, sda_in};
                adr_ph_q <= 1'b1;
                sel_q <= 1'b0;
                tx_idx_out <= 3'h0;
                nack_q <= 1'b0;
            end else if (bit_q == 4'h8) begin
                // Ninth clock: acknowledge slot
                bit_q <= 4'h0;
                if (adr_ph_q) begin
                    adr_ph_q <= 1'b0;
                    sel_q <= sh_q[7:1] == addr_in;
                    rd_q <= sh_q[0];
                    first_q <= 1'b1;
                end else if (sel_q && rd_q) begin
                    nack_q <= sda_in;
                    tx_idx_out <= 3'(tx_idx_out + 3'h1);
                    // Stop is only seen at the next frame, so the read ends here
                    if (sda_in) end_tgl_out <= ~end_tgl_out;
                end else if (sel_q) begin
                    rx_byte_out <= sh_q;
                    rx_first_out <= first_q;
                    rx_tgl_out <= ~rx_tgl_out;
                    first_q <= 1'b0;
                end
            end else begin
                sh_q <= {sh_q[6:0], sda_in};
                bit_q <= 4'(bit_q + 4'h1);
            end
        end
    end
    // Output side changes on falling SCL
    logic drv_q;
    wire [2:0] tx_bit = 3'(4'h7 - bit_q);
    always_ff @(negedge scl_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) drv_q <= 1'b0;
        else if (bit_q == 4'h8) drv_q <= adr_ph_q ? (sh_q[7:1] == addr_in)
            : (sel_q && !rd_q);
        else if (sel_q && rd_q && !nack_q && !adr_ph_q && bit_q < 4'h8)
            drv_q <= ~tx_byte_in[tx_bit];
        else drv_q <= 1'b0;
    end
    assign sda_out = 1'b0;
    assign sda_oe_out = drv_q;
endmodule : mic_i2c_slave
`default_nettype wire

// ---- inc/mic_pkg.sv ----
// Package for the magnetometer I2C command interpreter: codes, status bits, timing.
// Assumes a 50 MHz system clock and an I2C link clocked by the master's SCL.
package mic_pkg;
    localparam int unsigned SYS_CLK_HZ = 50_000_000;
    localparam int unsigned I2C_MAX_HZ = 400_000;
    localparam int unsigned BASE_INTERVAL_MS = 125;
    localparam int unsigned BASE_INTERVAL_CYC = (SYS_CLK_HZ / 1000) * BASE_INTERVAL_MS;
    localparam int unsigned MEAS_TIME_CYC = 16;
    // Command codes
    localparam logic [7:0] CMD_RD_LO = 8'h20;
    localparam logic [7:0] CMD_RD_HI = 8'h38;
    localparam logic [7:0] CMD_WR_LO = 8'h60;
    localparam logic [7:0] CMD_WR_HI = 8'h78;
    localparam logic [7:0] CMD_CHECKSUM = 8'h90;
    localparam logic [7:0] CMD_SINGLE = 8'hAA;
    localparam logic [7:0] CMD_CYCLIC = 8'hAB;
    localparam logic [7:0] CMD_OVS2 = 8'hAC;
    localparam logic [7:0] CMD_OVS16 = 8'hAF;
    localparam logic [7:0] CMD_STOP = 8'hBF;
    localparam logic [7:0] WR_BIT_FIELD_OFFSET = 8'h40;
    // Address rules
    localparam logic [6:0] ADDR_DEFAULT = 7'h10;
    localparam logic [6:0] ADDR_MIN = 7'h08;
    // Status bits
    localparam int unsigned ST_SAT = 0;
    localparam int unsigned ST_MEMERR = 2;
    localparam int unsigned ST_BUSY = 5;
    localparam int unsigned ST_VOK = 6;
    // Interval codes
    localparam logic [2:0] CYCLIC_INTERVAL_CODE_MIN = 3'h1;
    localparam logic [2:0] CYCLIC_INTERVAL_CODE_MAX = 3'h6;
    // Threshold modes
    localparam logic [1:0] TMODE_HIGH = 2'h1;
    localparam logic [1:0] TMODE_INV = 2'h2;
    localparam logic [1:0] TMODE_WIN = 2'h3;
    localparam logic [23:0] SIGN_MASK = 24'h80_0000;
    localparam logic [23:0] FULL_SCALE = 24'hFF_FFFF;
    localparam int unsigned USER_WORDS = 32;
    typedef enum logic [2:0] {MIC_IDLE, MIC_MEAS, MIC_ACC, MIC_DONE, MIC_CYCLIC} mic_state_e;
endpackage : mic_pkg

// ---- verif/magnetometer_i2c_command_control_tb.sv ----
// Bench for the command interpreter; all link clocking and framing comes from the master model, the slave answers.
// Assumes the base cyclic interval is shortened to 200 system clock cycles.
`timescale 1ns/1ps
`default_nettype none
module magnetometer_i2c_command_control_tb;
    import mic_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, sat = 1'b0, scl, m_oe, d_oe, mwr, ck, dout, cyc, busy;
    logic mrs, vok = 1'b1, merr = 1'b0;
    logic [23:0] fld = 24'hC0_0000, tmp = 24'h12_3456, t1 = 24'h80_0000, t2 = 24'h40_0000;
    logic [15:0] wd, mrd = 16'hBEEF;
    logic [5:0] ma;
    logic [2:0] cic = 3'h0;
    logic [1:0] tm = TMODE_HIGH;
    logic [8:0] r;
    logic [7:0] rb [7];
    int n_errors = 0, num_checks = 0, n_wr = 0, n_ck = 0, n_rd = 0;
    wire sda = ~(m_oe | d_oe);
    always #10 clk = ~clk;
    always @(posedge clk) begin
        n_wr <= n_wr + int'(mwr);
        n_ck <= n_ck + int'(ck);
        n_rd <= n_rd + int'(mrs);
    end
    mic_cmd_ctrl #(.INTERVAL_CYC(200)) u_mic_cmd_ctrl (.clk_sys_in(clk), .reset_n_in(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(d_oe), .field_raw_in(fld),
        .temp_raw_in(tmp), .sat_in(sat), .supply_ok_in(vok), .stored_addr_in(7'h05),
        .cyclic_interval_code_in(cic), .threshold_mode_in(tm), .threshold_one_in(t1),
        .threshold_two_in(t2), .field_offset_in(24'h00_0000), .temp_offset_in(24'h00_0000),
        .mem_error_in(merr), .mem_rd_out(mrs), .mem_wr_out(mwr), .mem_addr_out(ma),
        .mem_wdata_out(wd), .mem_rdata_in(mrd), .checksum_out(ck), .dout_out(dout),
        .cyclic_out(cyc), .busy_out(busy));
    mic_host u_mic_host (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        if (n_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic idle();
        int k = 0;
        repeat (8) @(posedge clk);
        while (busy !== 1'b0 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        chk({7'h0, busy}, 8'h00);
        if (k == 2000)
            conclude();
    endtask : idle
    // Only the bytes the command needs go out
    task automatic send(input logic [7:0] c, input logic [15:0] d, input logic two);
        u_mic_host.go();
        u_mic_host.xfer({ADDR_DEFAULT, 2'b01}, r);
        chk({7'h0, r[0]}, 8'h00);
        u_mic_host.xfer({c, 1'b1}, r);
        if (two) begin
            u_mic_host.xfer({d[15:8], 1'b1}, r);
            u_mic_host.xfer({d[7:0], 1'b1}, r);
        end
        u_mic_host.halt();
    endtask : send
    task automatic get(input int n);
        u_mic_host.go();
        u_mic_host.xfer({ADDR_DEFAULT, 2'b11}, r);
        for (int i = 0; i < n; i++) begin
            u_mic_host.xfer({8'hFF, i == n - 1}, r);
            rb[i] = r[8:1];
        end
        u_mic_host.halt();
    endtask : get
    task automatic meas(input logic [7:0] c);
        send(c, 16'h0000, 1'b0);
        idle();
        repeat (2) begin
            get(7);
            chk(rb[0], {2'b01, 5'h00, sat});
            for (int i = 0; i < 3; i++) begin
                chk(rb[1 + i], fld[23 - 8 * i -: 8]);
                chk(rb[4 + i], tmp[23 - 8 * i -: 8]);
            end
        end
        chk({7'h0, dout}, 8'h01);
    endtask : meas
    // Status-only read in cyclic mode refreshes the threshold output
    task automatic cyc_rd(input logic [1:0] m, input logic [23:0] f, input logic e);
        tm = m;
        fld = f;
        get(1);
        repeat (20) @(posedge clk);
        chk({7'h0, dout}, {7'h0, e});
    endtask : cyc_rd
    initial begin
        u_mic_host.xfer(9'h1FF, r);
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        // Clock the link reset out before the first frame
        u_mic_host.xfer(9'h1FF, r);
        u_mic_host.halt();
        meas(CMD_SINGLE);
        for (int c = 8'hAC; c <= 8'hAF; c++)
            meas(8'(c));
        sat = 1'b1;
        fld = 24'hFF_FFFF;
        meas(CMD_SINGLE);
        sat = 1'b0;
        send(8'h21, 16'h0000, 1'b0);
        idle();
        get(3);
        chk({2'b00, ma}, 8'h21);
        chk(8'(n_rd), 8'h01);
        chk(rb[1], 8'hBE);
        chk(rb[2], 8'hEF);
        send(8'h61, 16'h1234, 1'b1);
        idle();
        chk(8'(n_wr), 8'h01);
        chk(wd[15:8], 8'h12);
        chk(wd[7:0], 8'h34);
        send(CMD_CHECKSUM, 16'h0000, 1'b0);
        idle();
        chk(8'(n_ck), 8'h01);
        cic = CYCLIC_INTERVAL_CODE_MIN;
        send(CMD_CYCLIC, 16'h0000, 1'b0);
        repeat (20) @(posedge clk);
        chk({6'h00, cyc, busy}, 8'h03);
        vok = 1'b0;
        merr = 1'b1;
        get(1);
        chk(rb[0], 8'h25);
        vok = 1'b1;
        merr = 1'b0;
        send(8'h62, 16'h5555, 1'b1);
        fld = 24'h10_0000;
        repeat (300) @(posedge clk);
        chk(8'(n_wr), 8'h01);
        chk({7'h0, dout}, 8'h00);
        cic = CYCLIC_INTERVAL_CODE_MAX;
        sat = 1'b1;
        fld = 24'hC0_0000;
        get(7);
        repeat (20) @(posedge clk);
        chk({7'h0, dout}, 8'h01);
        get(7);
        chk(rb[0], 8'h61);
        chk(rb[1], 8'hFF);
        sat = 1'b0;
        cyc_rd(TMODE_INV, 24'h10_0000, 1'b1);
        cyc_rd(TMODE_WIN, 24'h60_0000, 1'b0);
        send(CMD_STOP, 16'h0000, 1'b0);
        repeat (20) @(posedge clk);
        chk({6'h00, cyc, busy}, 8'h00);
        conclude();
    end
endmodule : magnetometer_i2c_command_control_tb
`default_nettype wire

// ---- verif/mic_host.sv ----
// I2C master model: start, stop and nine-bit transfers at a 48 ns SCL period.
// Assumes SDA is wired-AND with a pull-up in the bench.
`timescale 1ns/1ps
`default_nettype none
module mic_host (
    // Bus
    output logic scl_out,
    output logic sda_oe_out,
    input wire logic sda_in
);
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // Only this side opens and closes frames
    task automatic go();
        sda_oe_out = 1'b1;
        #12 scl_out = 1'b0;
        #12;
    endtask : go
    task automatic halt();
        sda_oe_out = 1'b1;
        #12 scl_out = 1'b1;
        #12 sda_oe_out = 1'b0;
        #12;
    endtask : halt
    // A read's last bit nine is a not-acknowledge
    task automatic xfer(input logic [8:0] w, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_oe_out = ~w[i];
            #12 scl_out = 1'b1;
            #12 r[i] = sda_in;
            #12 scl_out = 1'b0;
            #12;
        end
    endtask : xfer
endmodule : mic_host
`default_nettype wire
